// ---- hw/rttp_pkg.sv ----
// Purpose: Constants for the retirement trap trace port.
// Assumes: One record per retirement slot, core clock domain.
// Notes:   Register offsets are byte addresses on APB.
package rttp_pkg;

  localparam int TRAP_W   = 14;
  localparam int ORDER_W  = 64;
  localparam int BIT_TRAP = 0;
  localparam int BIT_EXC  = 1;
  localparam int BIT_DBG  = 2;
  localparam int CODE_LSB = 3;
  localparam int CODE_MSB = 8;
  localparam int HALT_LSB = 9;
  localparam int HALT_MSB = 11;
  localparam int SUB_LSB  = 12;
  localparam int SUB_MSB  = 13;

  localparam logic [5:0] FC_NONE     = 6'h00;
  localparam logic [5:0] FC_IFETCH   = 6'h01;
  localparam logic [5:0] FC_ILLEGAL  = 6'h02;
  localparam logic [5:0] FC_BREAK    = 6'h03;
  localparam logic [5:0] FC_LOAD     = 6'h05;
  localparam logic [5:0] FC_STORE    = 6'h07;
  localparam logic [5:0] FC_ECALL_U  = 6'h08;
  localparam logic [5:0] FC_ECALL_M  = 6'h0B;
  localparam logic [5:0] FC_IBUS     = 6'h30;
  localparam logic [5:0] FC_IPARITY  = 6'h31;

  localparam logic [2:0] HR_NONE     = 3'h0;
  localparam logic [2:0] HR_EBREAK   = 3'h1;
  localparam logic [2:0] HR_TRIGGER  = 3'h2;
  localparam logic [2:0] HR_EXTREQ   = 3'h3;
  localparam logic [2:0] HR_STEP     = 3'h4;

  localparam logic [1:0] ST_BASE     = 2'h0;
  localparam logic [1:0] ST_FETCHPMP = 2'h1;
  localparam logic [1:0] ST_DATAPMP  = 2'h2;

  typedef enum logic [3:0] {
    EV_RETIRE    = 4'h0,
    EV_FETCH_PMA = 4'h1,
    EV_FETCH_PMP = 4'h2,
    EV_ILLEGAL   = 4'h3,
    EV_EBREAK    = 4'h4,
    EV_LOAD_IO   = 4'h5,
    EV_LOAD_PMP  = 4'h6,
    EV_STORE_IO  = 4'h7,
    EV_STORE_PMP = 4'h8,
    EV_ECALL     = 4'h9,
    EV_IBUS_ERR  = 4'hA,
    EV_IPARITY   = 4'hB,
    EV_TRIGGER   = 4'hC
  } rttp_event_t;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b01,
    MODE_DEBUG = 2'b10
  } rttp_mode_t;

  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_ORDER_LO = 8'h08;
  localparam logic [7:0]  ADDR_ORDER_HI = 8'h0C;
  localparam logic [7:0]  ADDR_LASTTRAP = 8'h10;
  localparam logic [7:0]  ADDR_TRAPCNT  = 8'h14;
  localparam int          CTRL_EBREAKM  = 0;
  localparam int          CTRL_STEP     = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  localparam logic [31:0] ZERO32        = 32'h0000_0000;

endpackage : rttp_pkg

// ---- hw/rttp_trace_port.sv ----
// Purpose: Builds trace records with trap fields and drives trap side effects.
// Assumes: Retire inputs come from core logic on the same clock.
// Notes:   APB slave answers in one access cycle, no wait states.
`timescale 1ns/100ps
module rttp_trace_port (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rstn,
  // Retirement events from the pipeline.
  input  wire logic               retireValid,
  input  wire logic [3:0]         retireKind,
  input  wire logic               privUser,
  input  wire logic               debugReturn,
  // Trace record.
  output logic                    rvfiValid,
  output logic [63:0]             rvfiOrder,
  output logic [13:0]             rvfiTrap,
  // Trap side effects.
  output logic                    mcauseWe,
  output logic                    mepcWe,
  output logic [5:0]              mcauseCode,
  output logic                    dpcWe,
  output logic                    dcsrWe,
  output logic [2:0]              dcsrCause,
  output logic                    trapJump,
  output logic                    debugJump,
  output logic                    debugMode,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr
);

  // Record builder: returns the 14-bit trap field for one retirement.
  function automatic logic [13:0] buildTrap(input logic [3:0] kind, input logic user,
                                            input logic inDbg, input logic brkm,
                                            input logic step);
    logic [5:0]  code;
    logic [1:0]  sub;
    logic        exc;
    logic        dbg;
    logic [2:0]  halt;
    logic [13:0] rec;
    code = rttp_pkg::FC_NONE;
    sub  = rttp_pkg::ST_BASE;
    exc  = 1'b0;
    dbg  = 1'b0;
    halt = rttp_pkg::HR_NONE;
    rec  = '0;
    case (kind)
      rttp_pkg::EV_FETCH_PMA: begin
        exc  = 1'b1; code = rttp_pkg::FC_IFETCH;
      end
      rttp_pkg::EV_FETCH_PMP: begin
        exc  = 1'b1; code = rttp_pkg::FC_IFETCH; sub = rttp_pkg::ST_FETCHPMP;
      end
      rttp_pkg::EV_ILLEGAL: begin
        exc  = 1'b1; code = rttp_pkg::FC_ILLEGAL;
      end
      rttp_pkg::EV_EBREAK: begin
        if (inDbg || brkm) begin
          dbg  = 1'b1; halt = rttp_pkg::HR_EBREAK;
        end else begin
          exc  = 1'b1; code = rttp_pkg::FC_BREAK;
        end
      end
      rttp_pkg::EV_LOAD_IO: begin
        exc  = 1'b1; code = rttp_pkg::FC_LOAD;
      end
      rttp_pkg::EV_LOAD_PMP: begin
        exc  = 1'b1; code = rttp_pkg::FC_LOAD; sub = rttp_pkg::ST_DATAPMP;
      end
      rttp_pkg::EV_STORE_IO: begin
        exc  = 1'b1; code = rttp_pkg::FC_STORE;
      end
      rttp_pkg::EV_STORE_PMP: begin
        exc  = 1'b1; code = rttp_pkg::FC_STORE; sub = rttp_pkg::ST_DATAPMP;
      end
      rttp_pkg::EV_ECALL: begin
        exc  = 1'b1;
        code = user ? rttp_pkg::FC_ECALL_U : rttp_pkg::FC_ECALL_M;
      end
      rttp_pkg::EV_IBUS_ERR: begin
        exc  = 1'b1; code = rttp_pkg::FC_IBUS;
      end
      rttp_pkg::EV_IPARITY: begin
        exc  = 1'b1; code = rttp_pkg::FC_IPARITY;
      end
      rttp_pkg::EV_TRIGGER: begin
        if (!inDbg) begin
          dbg  = 1'b1; halt = rttp_pkg::HR_TRIGGER;
        end
      end
      default: begin
        exc  = 1'b0;
      end
    endcase
    // A stepped instruction enters debug; an exception keeps its flag and code.
    if (step && !inDbg && !dbg) begin
      dbg  = 1'b1;
      halt = rttp_pkg::HR_STEP;
      sub  = rttp_pkg::ST_BASE;
    end
    // A debug trap reports no fault code unless an exception shares the slot.
    if (dbg && !exc) begin
      code = rttp_pkg::FC_NONE;
    end
    if (exc && !dbg) begin
      halt = rttp_pkg::HR_NONE;
    end
    if (exc || dbg) begin
      rec[rttp_pkg::BIT_TRAP]                     = 1'b1;
      rec[rttp_pkg::BIT_EXC]                      = exc;
      rec[rttp_pkg::BIT_DBG]                      = dbg;
      rec[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB]  = code;
      rec[rttp_pkg::HALT_MSB:rttp_pkg::HALT_LSB]  = halt;
      rec[rttp_pkg::SUB_MSB:rttp_pkg::SUB_LSB]    = sub;
    end
    return rec;
  endfunction : buildTrap

  rttp_pkg::rttp_mode_t modeQ;
  rttp_pkg::rttp_mode_t modeD;
  logic [1:0]           ctrlQ;
  logic [63:0]          countQ;
  logic [31:0]          trapCntQ;
  logic [13:0]          lastTrapQ;
  logic                 noCsrQ;
  logic [31:0]          rdSel;
  logic                 addrHit;

  wire logic        inDebug   = (modeQ == rttp_pkg::MODE_DEBUG);
  wire logic [13:0] newTrap   = buildTrap(retireKind, privUser, inDebug,
                                          ctrlQ[rttp_pkg::CTRL_EBREAKM],
                                          ctrlQ[rttp_pkg::CTRL_STEP]);
  wire logic        newIsTrap = newTrap[rttp_pkg::BIT_TRAP];
  wire logic        recTrap   = rvfiValid && rvfiTrap[rttp_pkg::BIT_TRAP];
  wire logic        recExc    = recTrap && rvfiTrap[rttp_pkg::BIT_EXC];
  wire logic        recDbg    = recTrap && rvfiTrap[rttp_pkg::BIT_DBG];
  wire logic        setup     = psel && !penable;
  wire logic        wrAccess  = psel && penable && pwrite && pready;

  // Debug entry follows a debug record; a debug return leaves it.
  always_comb begin
    modeD = modeQ;
    case (modeQ)
      rttp_pkg::MODE_RUN:   if (recDbg) modeD = rttp_pkg::MODE_DEBUG;
      rttp_pkg::MODE_DEBUG: if (debugReturn && !recDbg) modeD = rttp_pkg::MODE_RUN;
      default:              modeD = rttp_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modeQ <= rttp_pkg::MODE_RUN;
    end else begin
      modeQ <= modeD;
    end
  end

  // Record stage: one record per retirement, order counts every record.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvfiValid <= 1'b0;
      rvfiOrder <= '0;
      rvfiTrap  <= '0;
      countQ    <= '0;
      noCsrQ    <= 1'b0;
    end else begin
      rvfiValid <= retireValid;
      if (retireValid) begin
        rvfiOrder <= countQ;
        countQ    <= countQ + 64'h1;
        rvfiTrap  <= newTrap;
        noCsrQ    <= inDebug && (retireKind == rttp_pkg::EV_EBREAK);
      end
    end
  end

  // Side effects land in the cycle after a trap record.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mcauseWe   <= 1'b0;
      mepcWe     <= 1'b0;
      mcauseCode <= '0;
      dpcWe      <= 1'b0;
      dcsrWe     <= 1'b0;
      dcsrCause  <= '0;
      trapJump   <= 1'b0;
      debugJump  <= 1'b0;
    end else begin
      mcauseWe   <= recExc && !recDbg;
      mepcWe     <= recExc && !recDbg;
      mcauseCode <= rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB];
      dpcWe      <= recDbg && !noCsrQ;
      dcsrWe     <= recDbg && !noCsrQ;
      dcsrCause  <= rvfiTrap[rttp_pkg::HALT_MSB:rttp_pkg::HALT_LSB];
      trapJump   <= recExc && !recDbg;
      debugJump  <= recDbg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      debugMode <= 1'b0;
    end else begin
      debugMode <= (modeD == rttp_pkg::MODE_DEBUG);
    end
  end

  // Trap statistics visible to software.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trapCntQ  <= '0;
      lastTrapQ <= '0;
    end else if (retireValid && newIsTrap) begin
      trapCntQ  <= trapCntQ + 32'h1;
      lastTrapQ <= newTrap;
    end
  end

  // Register decode and read selection.
  assign addrHit = (paddr == rttp_pkg::ADDR_CTRL)     || (paddr == rttp_pkg::ADDR_STATUS)   ||
                   (paddr == rttp_pkg::ADDR_ORDER_LO) || (paddr == rttp_pkg::ADDR_ORDER_HI) ||
                   (paddr == rttp_pkg::ADDR_LASTTRAP) || (paddr == rttp_pkg::ADDR_TRAPCNT);
  assign rdSel   = (paddr == rttp_pkg::ADDR_CTRL)     ? {30'h0, ctrlQ} :
                   (paddr == rttp_pkg::ADDR_STATUS)   ? {31'h0, inDebug} :
                   (paddr == rttp_pkg::ADDR_ORDER_LO) ? countQ[31:0] :
                   (paddr == rttp_pkg::ADDR_ORDER_HI) ? countQ[63:32] :
                   (paddr == rttp_pkg::ADDR_LASTTRAP) ? {18'h0, lastTrapQ} :
                   (paddr == rttp_pkg::ADDR_TRAPCNT)  ? trapCntQ : rttp_pkg::ZERO32;

  // APB answer is prepared in the setup cycle and shown in the access cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !addrHit;
      prdata  <= (setup && !pwrite) ? rdSel : rttp_pkg::ZERO32;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlQ <= rttp_pkg::CTRL_RESET;
    end else if (wrAccess && (paddr == rttp_pkg::ADDR_CTRL)) begin
      ctrlQ <= pwdata[1:0];
    end
  end

  // Checks on the trace record and its side effects.
  logic        seenQ;
  logic [63:0] prevOrderQ;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seenQ      <= 1'b0;
      prevOrderQ <= '0;
    end else if (rvfiValid) begin
      seenQ      <= 1'b1;
      prevOrderQ <= rvfiOrder;
    end
  end

  wire logic plainRun = !inDebug && !ctrlQ[rttp_pkg::CTRL_STEP];

  AST_VALID_FOLLOWS: assert property (@(posedge clk) disable iff (!rstn)
    retireValid |=> rvfiValid)
    else $error("Retirement without a trace record.");

  AST_ORDER_STEP: assert property (@(posedge clk) disable iff (!rstn)
    rvfiValid && seenQ |-> rvfiOrder == prevOrderQ + 64'h1)
    else $error("Order did not advance by one.");

  AST_TRAP_FLAG: assert property (@(posedge clk) disable iff (!rstn)
    rvfiValid |-> rvfiTrap[rttp_pkg::BIT_TRAP] ==
                  (rvfiTrap[rttp_pkg::BIT_EXC] || rvfiTrap[rttp_pkg::BIT_DBG]))
    else $error("Trap flag disagrees with exception and debug flags.");

  AST_ZERO_NO_TRAP: assert property (@(posedge clk) disable iff (!rstn)
    rvfiValid && !rvfiTrap[rttp_pkg::BIT_TRAP] |-> rvfiTrap == 14'h0000)
    else $error("Record without trap has nonzero fields.");

  AST_BOTH_IS_STEP: assert property (@(posedge clk) disable iff (!rstn)
    rvfiValid && rvfiTrap[rttp_pkg::BIT_EXC] && rvfiTrap[rttp_pkg::BIT_DBG]
    |-> rvfiTrap[rttp_pkg::HALT_MSB:rttp_pkg::HALT_LSB] == rttp_pkg::HR_STEP)
    else $error("Exception and debug together without single step.");

  AST_EXC_SIDE: assert property (@(posedge clk) disable iff (!rstn)
    recExc && !recDbg |=> mcauseWe && mepcWe && trapJump && !debugJump)
    else $error("Exception side effects missing in the next cycle.");

  AST_EBREAK_DBG: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && inDebug && retireKind == rttp_pkg::EV_EBREAK
    |=> rvfiTrap[rttp_pkg::HALT_MSB:rttp_pkg::HALT_LSB] == rttp_pkg::HR_EBREAK
    ##1 debugJump && !dpcWe && !dcsrWe)
    else $error("EBREAK in debug mode handled wrongly.");

  AST_ECALL_M: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && plainRun && !privUser && retireKind == rttp_pkg::EV_ECALL
    |=> rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB] == rttp_pkg::FC_ECALL_M)
    else $error("Machine ECALL code wrong.");

  AST_FETCH_PMP: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && plainRun && retireKind == rttp_pkg::EV_FETCH_PMP
    |=> rvfiTrap[rttp_pkg::SUB_MSB:rttp_pkg::SUB_LSB] == rttp_pkg::ST_FETCHPMP
        && rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB] == rttp_pkg::FC_IFETCH)
    else $error("PMP fetch fault fields wrong.");

  AST_TRIGGER_DBG: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && !inDebug && retireKind == rttp_pkg::EV_TRIGGER
    |=> rvfiTrap[rttp_pkg::HALT_MSB:rttp_pkg::HALT_LSB] == rttp_pkg::HR_TRIGGER
    ##1 dpcWe && dcsrWe && debugMode)
    else $error("Trigger match did not enter debug.");

  AST_EXC_NO_HALT: assert property (@(posedge clk) disable iff (!rstn)
    rvfiValid && rvfiTrap[rttp_pkg::BIT_EXC] && !rvfiTrap[rttp_pkg::BIT_DBG]
    |-> rvfiTrap[rttp_pkg::HALT_MSB:rttp_pkg::HALT_LSB] == rttp_pkg::HR_NONE)
    else $error("Exception record carries a halt reason.");

  AST_DBG_NO_CODE: assert property (@(posedge clk) disable iff (!rstn)
    rvfiValid && rvfiTrap[rttp_pkg::BIT_DBG] && !rvfiTrap[rttp_pkg::BIT_EXC]
    |-> rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB] == rttp_pkg::FC_NONE)
    else $error("Debug record carries a fault code.");

  AST_DBG_SIDE: assert property (@(posedge clk) disable iff (!rstn)
    recDbg && !noCsrQ |=> dpcWe && dcsrWe && debugJump && !mcauseWe && !trapJump)
    else $error("Debug side effects missing in the next cycle.");

  AST_QUIET_NO_TRAP: assert property (@(posedge clk) disable iff (!rstn)
    !recTrap |=> !mcauseWe && !mepcWe && !dpcWe && !dcsrWe && !trapJump && !debugJump)
    else $error("Side effect without a trap record.");

  AST_EBREAK_EXC: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && plainRun && !ctrlQ[rttp_pkg::CTRL_EBREAKM]
    && retireKind == rttp_pkg::EV_EBREAK
    |=> rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB] == rttp_pkg::FC_BREAK
        && rvfiTrap[rttp_pkg::BIT_EXC] && !rvfiTrap[rttp_pkg::BIT_DBG])
    else $error("EBREAK without debug entry reported wrongly.");

  AST_EBREAK_M: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && !inDebug && ctrlQ[rttp_pkg::CTRL_EBREAKM]
    && retireKind == rttp_pkg::EV_EBREAK
    |=> rvfiTrap[rttp_pkg::HALT_MSB:rttp_pkg::HALT_LSB] == rttp_pkg::HR_EBREAK
        && !rvfiTrap[rttp_pkg::BIT_EXC] ##1 dpcWe && dcsrWe)
    else $error("EBREAK with debug entry reported wrongly.");

  AST_IBUS: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && plainRun && retireKind == rttp_pkg::EV_IBUS_ERR
    |=> rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB] == rttp_pkg::FC_IBUS
        && rvfiTrap[rttp_pkg::SUB_MSB:rttp_pkg::SUB_LSB] == rttp_pkg::ST_BASE)
    else $error("Fetch bus error fields wrong.");

  AST_IPARITY: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && plainRun && retireKind == rttp_pkg::EV_IPARITY
    |=> rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB] == rttp_pkg::FC_IPARITY
        && rvfiTrap[rttp_pkg::SUB_MSB:rttp_pkg::SUB_LSB] == rttp_pkg::ST_BASE)
    else $error("Fetch parity fault fields wrong.");

  AST_LOAD_PMP: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && plainRun && retireKind == rttp_pkg::EV_LOAD_PMP
    |=> rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB] == rttp_pkg::FC_LOAD
        && rvfiTrap[rttp_pkg::SUB_MSB:rttp_pkg::SUB_LSB] == rttp_pkg::ST_DATAPMP)
    else $error("PMP load fault fields wrong.");

  AST_STORE_PMP: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && plainRun && retireKind == rttp_pkg::EV_STORE_PMP
    |=> rvfiTrap[rttp_pkg::CODE_MSB:rttp_pkg::CODE_LSB] == rttp_pkg::FC_STORE
        && rvfiTrap[rttp_pkg::SUB_MSB:rttp_pkg::SUB_LSB] == rttp_pkg::ST_DATAPMP)
    else $error("PMP store fault fields wrong.");

  AST_STEP_HALT: assert property (@(posedge clk) disable iff (!rstn)
    retireValid && !inDebug && ctrlQ[rttp_pkg::CTRL_STEP]
    && retireKind != rttp_pkg::EV_EBREAK && retireKind != rttp_pkg::EV_TRIGGER
    |=> rvfiTrap[rttp_pkg::BIT_DBG]
        && rvfiTrap[rttp_pkg::HALT_MSB:rttp_pkg::HALT_LSB] == rttp_pkg::HR_STEP)
    else $error("Stepped instruction did not report a step halt.");

  COV_EXCEPTION: cover property (@(posedge clk) disable iff (!rstn) recExc && !recDbg);
  COV_DEBUG:     cover property (@(posedge clk) disable iff (!rstn) recDbg && !recExc);
  COV_STEP_EXC:  cover property (@(posedge clk) disable iff (!rstn) recDbg && recExc);
  COV_APB_ERR:   cover property (@(posedge clk) disable iff (!rstn) pready && pslverr);
  COV_APB_WR:    cover property (@(posedge clk) disable iff (!rstn) wrAccess);

endmodule : rttp_trace_port

// ---- tb/rttp_trace_monitor.sv ----
// Purpose: Trace consumer that tallies records and flags bad ones.
// Assumes: One record per cycle at most, core clock.
// Notes:   Outputs other than valid are ignored while valid is low.
`timescale 1ns/100ps
module rttp_trace_monitor (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Trace record.
  input  wire logic        rvfiValid,
  input  wire logic [63:0] rvfiOrder,
  input  wire logic [13:0] rvfiTrap,
  // Tallies.
  output int               recCount,
  output int               badCount
);
  logic [63:0] nextOrd;
  logic        recBad;

  assign recBad = (rvfiOrder !== nextOrd)
                | (rvfiTrap[0] !== (rvfiTrap[1] | rvfiTrap[2]))
                | (!rvfiTrap[0] && rvfiTrap !== 14'h0000)
                | (rvfiTrap[1] && !rvfiTrap[2] && rvfiTrap[11:9] !== 3'h0)
                | (rvfiTrap[2] && !rvfiTrap[1] && rvfiTrap[8:3] !== 6'h00);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      recCount <= 0;
      badCount <= 0;
      nextOrd  <= 64'h0000_0000_0000_0000;
    end else if (rvfiValid === 1'b1) begin
      recCount <= recCount + 1;
      badCount <= badCount + int'(recBad);
      nextOrd  <= rvfiOrder + 64'h1;
    end
  end
endmodule : rttp_trace_monitor

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the trap trace port.
// Assumes: Zero-wait APB slave, records one cycle after retire.
// Notes:   Each scenario is a task that judges its own results.
`timescale 1ns/100ps
module tb;
  logic        clk, rstn, retireValid, privUser, debugReturn;
  logic [3:0]  retireKind;
  logic        rvfiValid, mcauseWe, mepcWe, dpcWe, dcsrWe;
  logic        trapJump, debugJump, debugMode;
  logic [63:0] rvfiOrder, nOrd;
  logic [13:0] rvfiTrap;
  logic [5:0]  mcauseCode;
  logic [2:0]  dcsrCause;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, tests_run, recCount, badCount;

  localparam logic [5:0] EXC_FX = 6'h38;
  localparam logic [5:0] DBG_FX = 6'h07;

  rttp_trace_port u_rttp_trace_port (.clk(clk), .rstn(rstn), .retireValid(retireValid),
    .retireKind(retireKind), .privUser(privUser), .debugReturn(debugReturn),
    .rvfiValid(rvfiValid), .rvfiOrder(rvfiOrder), .rvfiTrap(rvfiTrap), .mcauseWe(mcauseWe),
    .mepcWe(mepcWe), .mcauseCode(mcauseCode), .dpcWe(dpcWe), .dcsrWe(dcsrWe),
    .dcsrCause(dcsrCause), .trapJump(trapJump), .debugJump(debugJump),
    .debugMode(debugMode), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  rttp_trace_monitor u_rttp_trace_monitor (.clk(clk), .rstn(rstn), .rvfiValid(rvfiValid),
    .rvfiOrder(rvfiOrder), .rvfiTrap(rvfiTrap), .recCount(recCount), .badCount(badCount));

  function automatic logic [13:0] rec(input logic e, input logic d, input logic [5:0] c,
                                      input logic [2:0] h, input logic [1:0] s);
    return {s, h, c, d, e, 1'b1};
  endfunction : rec

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk("pready", pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic runRec(input logic [3:0] k, input logic u, input logic [13:0] e,
                        input logic [5:0] fx);
    @(posedge clk);
    retireValid <= 1'b1;
    retireKind  <= k;
    privUser    <= u;
    @(posedge clk);
    retireValid <= 1'b0;
    #1;
    chk("valid", rvfiValid, 1'b1);
    chk("order", rvfiOrder, nOrd);
    chk("trap", rvfiTrap, e);
    nOrd++;
    @(posedge clk);
    #1;
    chk("valid low", rvfiValid, 1'b0);
    chk("effects", {mcauseWe, mepcWe, trapJump, dpcWe, dcsrWe, debugJump}, fx);
    if (e[1] && !e[2]) chk("mcause", mcauseCode, e[8:3]);
    if (e[2]) chk("dcause", dcsrCause, e[11:9]);
  endtask : runRec

  task automatic leaveDebug();
    @(posedge clk);
    debugReturn <= 1'b1;
    @(posedge clk);
    debugReturn <= 1'b0;
    #1;
    chk("mode", debugMode, 1'b0);
  endtask : leaveDebug

  task automatic testExceptions();
    runRec(4'h0, 1'b0, 14'h0000, 6'h00);
    runRec(4'h1, 1'b0, rec(1, 0, 6'h01, 0, 0), EXC_FX);
    runRec(4'h2, 1'b0, rec(1, 0, 6'h01, 0, 1), EXC_FX);
    runRec(4'h3, 1'b0, rec(1, 0, 6'h02, 0, 0), EXC_FX);
    runRec(4'h4, 1'b0, rec(1, 0, 6'h03, 0, 0), EXC_FX);
    runRec(4'h5, 1'b0, rec(1, 0, 6'h05, 0, 0), EXC_FX);
    runRec(4'h6, 1'b0, rec(1, 0, 6'h05, 0, 2), EXC_FX);
    runRec(4'h7, 1'b0, rec(1, 0, 6'h07, 0, 0), EXC_FX);
    runRec(4'h8, 1'b0, rec(1, 0, 6'h07, 0, 2), EXC_FX);
    runRec(4'h9, 1'b1, rec(1, 0, 6'h08, 0, 0), EXC_FX);
    runRec(4'h9, 1'b0, rec(1, 0, 6'h0B, 0, 0), EXC_FX);
    runRec(4'hA, 1'b0, rec(1, 0, 6'h30, 0, 0), EXC_FX);
    runRec(4'hB, 1'b0, rec(1, 0, 6'h31, 0, 0), EXC_FX);
  endtask : testExceptions

  task automatic testDebug();
    runRec(4'hC, 1'b0, rec(0, 1, 6'h00, 3'h2, 0), DBG_FX);
    chk("mode", debugMode, 1'b1);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("status", rd, 32'h0000_0001);
    runRec(4'h4, 1'b0, rec(0, 1, 6'h00, 3'h1, 0), 6'h01);
    leaveDebug();
  endtask : testDebug

  task automatic testEbreakm();
    apb(1'b1, 8'h00, 32'h0000_0001);
    runRec(4'h4, 1'b0, rec(0, 1, 6'h00, 3'h1, 0), DBG_FX);
    leaveDebug();
    apb(1'b1, 8'h00, 32'h0000_0002);
    runRec(4'h0, 1'b0, rec(0, 1, 6'h00, 3'h4, 0), DBG_FX);
    leaveDebug();
    runRec(4'h6, 1'b0, rec(1, 1, 6'h05, 3'h4, 0), DBG_FX);
    leaveDebug();
    apb(1'b1, 8'h00, 32'h0000_0000);
  endtask : testEbreakm

  task automatic testRegsAndBurst();
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("order reg", rd, nOrd[31:0]);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("order hi", rd, nOrd[63:32]);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("last trap", rd, {18'h0, rec(1, 1, 6'h05, 3'h4, 2'h0)});
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("trap count", rd, 32'h0000_0011);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("slverr", err, 1'b1);
    chk("rdata", rd, 32'h0000_0000);
    @(posedge clk);
    retireValid <= 1'b1;
    retireKind  <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      if (i == 2) retireValid <= 1'b0;
      #1;
      chk("burst valid", rvfiValid, 1'b1);
      chk("burst order", rvfiOrder, nOrd);
      nOrd++;
    end
    repeat (2) @(posedge clk);
    chk("monitor bad", badCount, 0);
    chk("monitor count", recCount, nOrd);
  endtask : testRegsAndBurst

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #20000;
    n_fail++;
    final_report();
  end

  initial begin
    {rstn, retireValid, privUser, debugReturn, psel, penable, pwrite} = 7'h00;
    retireKind = 4'h0;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    nOrd       = 64'h0;
    n_fail     = 0;
    tests_run  = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    testExceptions();
    testDebug();
    testEbreakm();
    testRegsAndBurst();
    final_report();
  end
endmodule : tb
